// ==== include/tty_check_map.vh ====
// constants for the teletype check, burst and switch block
`ifndef TTY_CHECK_MAP_VH
`define TTY_CHECK_MAP_VH
`define TTY_CHANNELS 25
`define TTY_BURST_WIDTH 5
`define TTY_POS_WIDTH 6
`define TTY_POS_START_SEARCH 6'h2d
`define TTY_POS_STOP_SEARCH 6'h33
`define TTY_BURST_RESET 5'h00
`define TTY_PARITY_RESET 25'h0000000
`define TTY_LINE_RESET 25'h0000000
`endif

// ==== rtl/teletype_check_burst_switch.v ====
// teletype parity check, burst counter and duplex/test output switching
// Operation
// [R1] at position 51 the stop-search pulse passes if any parity flop is set
// [R2] the gated stop-search pulse clears all set parity flops
// [R3] each one bit moved to a line flop toggles its channel parity flop; a shift on the edge of the gated stop-search pulse clears the flop instead
// [R4] message is correct only when ones count, parity included, is even
// [R5] at next stop-search, any set parity flop raises the parity alarm
// [R6] the alarm pulse also clears set parity flops for the next check
// [R7] burst number is five bits held in five flip-flops
// [R8] burst counter is plain binary, modulo 32, wrapping to zero
// [R9] burst counter steps by one at start of search, position 45
// [R10] only the active computer's outputs reach the line terminal equipment
// [R11] each of the 25 teletype outputs has its own identical switch path
// [R12] standby outputs go to the test busses only during test operations
// [R13] search level set at position 45, cleared at position 51
// [R14] line flop set by a one bit shifted out; one opens the line
// [R15] one parity flop per channel so any channel raises the alarm
`timescale 1ns/100ps
`default_nettype none
`include "tty_check_map.vh"
module teletype_check_burst_switch #(
  parameter CHANNELS = `TTY_CHANNELS,
  parameter BURST_WIDTH = `TTY_BURST_WIDTH
) (
  // clock and reset
  input wire mclk_i,
  input wire resetn_i,
  // timing counter position, pulse strobe when it steps
  input wire [`TTY_POS_WIDTH-1:0] counter_pos_i,
  input wire counter_step_i,
  // bits leaving the serial staging register
  input wire shift_i,
  input wire [CHANNELS-1:0] staging_bits_i,
  // duplex and test status
  input wire active_i,
  input wire test_mode_i,
  // line outputs to terminal equipment, open = space
  output wire [CHANNELS-1:0] line_open_o,
  output wire [CHANNELS-1:0] line_connect_o,
  // standby routing to test busses
  output wire [CHANNELS-1:0] test_bus_o,
  output wire [CHANNELS-1:0] test_connect_o,
  // status
  output reg search_o,
  output reg [BURST_WIDTH-1:0] burst_count_o,
  output reg parity_alarm_o,
  output wire [CHANNELS-1:0] parity_state_o
);

  // one-hot phase of the teletype cycle
  localparam [1:0] PHASE_READOUT = 2'b01;
  localparam [1:0] PHASE_SEARCH = 2'b10;

  // timing counter positions that open and close search time
  localparam [`TTY_POS_WIDTH-1:0] POS_START = `TTY_POS_START_SEARCH;
  localparam [`TTY_POS_WIDTH-1:0] POS_STOP = `TTY_POS_STOP_SEARCH;

  // reset values and the counter increment
  localparam [BURST_WIDTH-1:0] BURST_INIT = `TTY_BURST_RESET;
  localparam [BURST_WIDTH-1:0] BURST_ONE = {{(BURST_WIDTH-1){1'b0}}, 1'b1};
  localparam [CHANNELS-1:0] PARITY_INIT = `TTY_PARITY_RESET;
  localparam [CHANNELS-1:0] LINE_INIT = `TTY_LINE_RESET;

  // decoded timing events
  wire start_search;
  wire stop_search;
  wire any_set;
  wire gated_stop;
  wire alarm_fire;

  // search phase
  reg [1:0] phase;
  reg [1:0] next_phase;
  reg next_search;

  // burst counter
  reg [BURST_WIDTH-1:0] next_burst_count;

  // alarm pulse
  reg next_parity_alarm;

  // per-channel flop states gathered into vectors
  wire [CHANNELS-1:0] parity; // [R15]
  wire [CHANNELS-1:0] line_ff;

  // position decode shared by both search edges
  function pos_event;
    input step;
    input [`TTY_POS_WIDTH-1:0] pos;
    input [`TTY_POS_WIDTH-1:0] target;
    begin
      pos_event = step && (pos == target);
    end
  endfunction

  // true when any flop of the group holds a one
  function any_one;
    input [CHANNELS-1:0] bits;
    integer i;
    begin
      any_one = 1'b0;
      for (i = 0; i < CHANNELS; i = i + 1) begin
        any_one = any_one | bits[i];
      end
    end
  endfunction

  // complement of one check flop by one shifted bit
  function parity_next_bit;
    input current;
    input shifted;
    begin
      parity_next_bit = current ^ shifted;
    end
  endfunction

  // binary step of the burst number; the carry out of the top bit is dropped
  function [BURST_WIDTH-1:0] step_burst;
    input [BURST_WIDTH-1:0] count;
    begin
      step_burst = count + BURST_ONE;
    end
  endfunction

  // a relay contact passes its bit only while closed
  function relay_pass;
    input closed;
    input data;
    begin
      relay_pass = closed & data;
    end
  endfunction

  // events from the timing counter
  assign start_search = pos_event(counter_step_i, counter_pos_i, POS_START);
  assign stop_search = pos_event(counter_step_i, counter_pos_i, POS_STOP);

  // even count of ones leaves all flops clear; any one flags an error
  assign any_set = any_one(parity); // [R4]

  // the stop-search pulse passes only when some flop is set
  assign gated_stop = stop_search && any_set; // [R1]

  // the gated pulse is both the alarm and the clear
  assign alarm_fire = gated_stop; // [R5]

  // outputs of the check group
  assign parity_state_o = parity;

  // search phase: next state
  always @* begin
    next_phase = phase;
    case (phase)
      PHASE_READOUT: begin
        if (start_search) begin
          next_phase = PHASE_SEARCH; // [R13]
        end
      end
      PHASE_SEARCH: begin
        if (stop_search) begin
          next_phase = PHASE_READOUT; // [R13]
        end
      end
      default: begin
        next_phase = PHASE_READOUT;
      end
    endcase
    next_search = (next_phase == PHASE_SEARCH);
  end

  // search phase: state and level
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase <= PHASE_READOUT;
      search_o <= 1'b0;
    end else begin
      phase <= next_phase;
      search_o <= next_search; // [R13]
    end
  end

  // burst counter: next value, wraps naturally at the top
  always @* begin
    next_burst_count = burst_count_o;
    if (start_search) begin
      next_burst_count = step_burst(burst_count_o); // [R8] [R9]
    end
  end

  // burst counter: five flops
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      burst_count_o <= BURST_INIT;
    end else begin
      burst_count_o <= next_burst_count; // [R7]
    end
  end

  // alarm: next value
  always @* begin
    next_parity_alarm = 1'b0;
    if (alarm_fire) begin
      next_parity_alarm = 1'b1; // [R5]
    end
  end

  // alarm: one-cycle pulse to the alarm control
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      parity_alarm_o <= 1'b0;
    end else begin
      parity_alarm_o <= next_parity_alarm;
    end
  end

  genvar ch;

  // parity check flops, one per channel
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_check
      reg check_ff;
      reg next_check_ff;

      // clear beats a shift that lands on the same edge
      always @* begin
        next_check_ff = check_ff;
        if (alarm_fire) begin
          next_check_ff = 1'b0; // [R2] [R6]
        end else if (shift_i) begin
          next_check_ff = parity_next_bit(check_ff, staging_bits_i[ch]); // [R3]
        end
      end

      // check flop state
      always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          check_ff <= PARITY_INIT[ch];
        end else begin
          check_ff <= next_check_ff;
        end
      end

      assign parity[ch] = check_ff; // [R15]
    end
  endgenerate

  // line flops, one per channel
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_line
      reg line_bit;
      reg next_line_bit;

      // takes each bit shifted out and holds it until the next shift
      always @* begin
        next_line_bit = line_bit;
        if (shift_i) begin
          next_line_bit = staging_bits_i[ch]; // [R14]
        end
      end

      // line flop state
      always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          line_bit <= LINE_INIT[ch];
        end else begin
          line_bit <= next_line_bit;
        end
      end

      assign line_ff[ch] = line_bit;
    end
  endgenerate

  // relay paths: active side to the line, standby to the test busses
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_relay
      reg relay_line;
      reg relay_open;
      reg relay_test;
      reg relay_test_bit;

      always @* begin
        relay_line = 1'b0;
        relay_test = 1'b0;
        if (active_i) begin
          relay_line = 1'b1; // [R10] [R11]
        end else if (test_mode_i) begin
          relay_test = 1'b1; // [R12]
        end
        relay_open = relay_pass(relay_line, line_ff[ch]); // [R10] [R14]
        relay_test_bit = relay_pass(relay_test, line_ff[ch]); // [R12]
      end

      assign line_connect_o[ch] = relay_line;
      assign line_open_o[ch] = relay_open;
      assign test_connect_o[ch] = relay_test;
      assign test_bus_o[ch] = relay_test_bit;
    end
  endgenerate

endmodule // teletype_check_burst_switch
`default_nettype wire

// ==== tb/alarm_control_model.sv ====
// alarm control model: counts parity alarms from the block
`timescale 1ns/100ps
`default_nettype none
module alarm_ctl (input wire logic mclk_i, parity_alarm_o, output logic [7:0] alarms);
  initial alarms = 8'h00;
  always @(posedge mclk_i) if (parity_alarm_o) alarms <= alarms + 8'h01;
endmodule // alarm_ctl
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the teletype check block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk_i = 0, resetn_i = 0, counter_step_i = 0, shift_i = 0, active_i = 1, test_mode_i = 1;
  logic [5:0] counter_pos_i = 6'h01;
  logic [24:0] staging_bits_i = 25'h0, line_open_o, parity_state_o;
  logic [24:0] line_connect_o, test_bus_o, test_connect_o;
  logic [4:0] burst_count_o;
  logic [7:0] alarms;
  logic search_o, parity_alarm_o;
  int miscompares = 0, checks_done = 0;
  teletype_check_burst_switch uut (.*);
  alarm_ctl far (.*);
  initial forever #12.5 mclk_i = ~mclk_i;
  task chk(input logic [32:0] s, e);
    checks_done++;
    if (s !== e) begin miscompares++; $display("MISMATCH %0t bad value", $time); end
  endtask
  // one event per call: zero data means a counter step, else a shift
  task ev(input logic [5:0] p, input logic [24:0] d);
    @(negedge mclk_i) {counter_pos_i, staging_bits_i} = {p, d};
    {counter_step_i, shift_i} = {d == 25'h0, d != 25'h0};
    @(negedge mclk_i) {counter_step_i, shift_i} = 2'h0;
    @(negedge mclk_i);
  endtask
  task parity_check;
    ev(6'h10, 25'h1000003); ev(6'h10, 25'h0000002);
    chk({8'h0, parity_state_o}, 33'h1000001);
    chk({8'h0, line_open_o}, 33'h2);
    ev(6'h33, 25'h0);
    chk({alarms, parity_state_o}, {8'h1, 25'h0});
    ev(6'h10, 25'h5); ev(6'h10, 25'h5); ev(6'h33, 25'h0);
    chk({alarms, parity_state_o}, {8'h1, 25'h0});
  endtask
  task burst_wrap;
    repeat (33) ev(6'h2d, 25'h0);
    chk({27'h0, search_o, burst_count_o}, 33'h21);
    ev(6'h33, 25'h0);
    chk({32'h0, search_o}, 33'h0);
    chk({27'h0, search_o, burst_count_o}, 33'h01);
  endtask
  task duplex;
    ev(6'h10, 25'h1ffffff);
    chk({8'h0, line_open_o}, 33'h1ffffff);
    chk({8'h0, line_connect_o}, 33'h1ffffff);
    chk({8'h0, test_connect_o}, 33'h0);
    active_i = 0;
    #1 chk({8'h0, line_open_o}, 33'h0);
    chk({8'h0, line_connect_o}, 33'h0);
    chk({8'h0, test_bus_o}, 33'h1ffffff);
    chk({8'h0, test_connect_o}, 33'h1ffffff);
    @(negedge mclk_i) test_mode_i = 0;
    #1 chk({8'h0, test_bus_o}, 33'h0);
    chk({8'h0, test_connect_o}, 33'h0);
    @(negedge mclk_i) {active_i, test_mode_i} = 2'h3;
  endtask
  task reset_mid;
    ev(6'h2d, 25'h0);
    @(negedge mclk_i) resetn_i = 0;
    @(negedge mclk_i) resetn_i = 1;
    chk({8'h0, parity_state_o}, 33'h0);
    chk({27'h0, search_o, burst_count_o}, 33'h0);
    ev(6'h33, 25'h0);
    chk({25'h0, alarms}, 33'h1);
  endtask
  task stop_test;
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge mclk_i);
    resetn_i = 1;
    parity_check; burst_wrap; duplex; reset_mid; stop_test;
  end
  initial begin #20000; miscompares++; stop_test; end
endmodule // testbench
`default_nettype wire

// ==== tb/tty_check_properties.sv ====
// assertions on the teletype check block ports
`timescale 1ns/100ps
`default_nettype none
module tty_rules (input wire logic mclk_i, resetn_i, counter_step_i, shift_i, search_o,
  parity_alarm_o, active_i, test_mode_i, input wire logic [5:0] counter_pos_i,
  input wire logic [4:0] burst_count_o, input wire logic [24:0] staging_bits_i, parity_state_o,
  line_open_o, line_connect_o, test_connect_o);
  wire go = counter_step_i && counter_pos_i == 6'h2d;
  wire halt = counter_step_i && counter_pos_i == 6'h33;
  wire bad = |parity_state_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  alarm_on_a: assert property (halt && bad |=> parity_alarm_o) else $error("alarm");
  alarm_off_a: assert property (halt && !bad |=> !parity_alarm_o) else $error("alarm");
  parity_clear_a: assert property (halt |=> !bad) else $error("clear");
  parity_flip_a: assert property (shift_i && !halt |=> parity_state_o ==
    ($past(parity_state_o) ^ $past(staging_bits_i))) else $error("toggle");
  burst_step_a: assert property (go |=> burst_count_o ==
    $past(burst_count_o) + 5'h01) else $error("step");
  burst_hold_a: assert property (!go |=> $stable(burst_count_o)) else $error("hold");
  search_on_a: assert property (go |=> search_o) else $error("search");
  search_off_a: assert property (halt |=> !search_o) else $error("search");
  sequence stop_with_error;
    halt && bad;
  endsequence
  sequence alarm_then_quiet;
    parity_alarm_o ##1 !parity_alarm_o;
  endsequence
  alarm_pulse_a: assert property (stop_with_error |=> alarm_then_quiet) else $error("pulse");
  relay_route_a: assert property (line_connect_o == {25{active_i}} &&
    test_connect_o == {25{!active_i && test_mode_i}}) else $error("route");
  line_idle_a: assert property (!active_i |-> line_open_o == 25'h0) else $error("line");
endmodule // tty_rules
bind teletype_check_burst_switch tty_rules props (.*);
`default_nettype wire
